// ==== core/abu_core.sv ====
/*
 * Address breakpoint unit: compare of the program address against a
 * software-written break address, software break, break state tracking,
 * timer freeze, watchdog disable, flag-clear permission, wait-exit flag and
 * a maskable interrupt output.
 * Assumes the CPU marks opcode fetches, instruction boundaries and the
 * return-from-interrupt, and that the register port master never waits.
 */
`timescale 1ns/1ps

// How it works
// - Address equal to break address raises the breakpoint request.
// - A break forces the software interrupt opcode into the instruction register.
// - A break vectors to FFFC, or FEFC in monitor mode.
// - Writing one to break-active breaks just before the next instruction.
// - Match on an opcode address stops that instruction before it runs.
// - Match on an operand address lets the instruction finish first.
// - Return-from-interrupt inside the break handler ends the break state.
// - Break enable at bit 7, read/write, gates full 16-bit matches; reset clears.
// - Match sets break-active; reset clears; software clears it by writing zero.
// - Same address gives no new break until the address is rewritten.
// - Address high and low bytes are read/write and reset to zero.
// - In break, status clears are allowed only with the flag-clear enable.
// - The timer counter stops for the whole break state.
// - Watchdog disabled in break while the test voltage is present.
// - Wait-exit flag reads one after a break left wait; write zero clears.
// - No address-match break in wait or stop modes.
module abu_core
    import abu_pkg::*;
#(
    parameter logic [7:0] SWI_OPCODE = 8'h00
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [15:0] cpu_addr_in,
    input wire logic cpu_addr_valid_in,
    input wire logic cpu_opcode_fetch_in,
    input wire logic cpu_instr_boundary_in,
    input wire logic cpu_return_from_interrupt_in,
    input wire logic monitor_mode_in,
    input wire logic wait_mode_in,
    input wire logic stop_mode_in,
    input wire logic test_high_voltage_in,
    output logic breakpoint_request_out,
    output logic force_swi_out,
    output logic [7:0] software_interrupt_opcode_out,
    output logic [15:0] break_vector_out,
    output logic break_state_out,
    output logic timer_freeze_out,
    output logic watchdog_disable_out,
    output logic flag_clear_allow_out,
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    // Limitation: a match while a break is pending or active only sets
    // status; it never queues a second break behind the first.
    typedef struct packed {
        // Break sequencing
        abu_state_type state;

        // Software-visible registers
        logic [7:0] addr_high;
        logic [7:0] addr_low;
        logic break_enable;
        logic break_active;
        logic flag_clear_en;
        logic wait_exit;

        // Comparator fires once per written address
        logic spent;

        // Test-voltage pin filter
        logic [ABU_SYNC_LEN-1:0] tst_sync;
        logic tst_level;

        // Interrupt status and mask
        logic [ABU_IRQ_W-1:0] irq_status;
        logic [ABU_IRQ_W-1:0] irq_mask;
        logic irq;

        // Registered outputs
        logic breakpoint_request;
        logic force_swi;
        logic [7:0] opcode;
        logic [15:0] vector;
        logic timer_freeze;
        logic wd_disable;
        logic clear_allow;
        logic [7:0] rdata;
    } abu_regs_type;

    abu_regs_type s_reg;
    abu_regs_type s_next;

    function automatic logic sel(input logic [15:0] addr, input logic [15:0] off);
        sel = (addr == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    // Decoded strobes and events of the current cycle
    logic addr_match;
    logic take_now;
    logic wr_ctrl;
    logic wr_high;
    logic wr_low;
    logic soft_req;
    logic [ABU_IRQ_W-1:0] irq_events;

    always_comb
    begin
        s_next = s_reg;

        // Write decode
        wr_ctrl = reg_wr_in && sel(reg_addr_in, ABU_OFF_CONTROL_STATUS);
        wr_high = reg_wr_in && sel(reg_addr_in, ABU_OFF_ADDR_HIGH);
        wr_low = reg_wr_in && sel(reg_addr_in, ABU_OFF_ADDR_LOW);
        soft_req = wr_ctrl && reg_wdata_in[ABU_BIT_BREAK_ACTIVE];

        // Address bus is frozen in low-power modes, so never compare there
        addr_match = cpu_addr_valid_in && s_reg.break_enable && !s_reg.spent
            && !wait_mode_in && !stop_mode_in
            && (cpu_addr_in == {s_reg.addr_high, s_reg.addr_low});
        take_now = 1'b0;
        irq_events = ABU_RST_IRQ;
        s_next.breakpoint_request = addr_match;
        s_next.force_swi = 1'b0;
        s_next.opcode = SWI_OPCODE;

        // Register writes
        if (wr_high)
        begin
            s_next.addr_high = reg_wdata_in;
        end

        if (wr_low)
        begin
            s_next.addr_low = reg_wdata_in;
        end

        // A new address re-arms the comparator
        if (wr_high || wr_low)
        begin
            s_next.spent = 1'b0;
        end

        if (wr_ctrl)
        begin
            s_next.break_enable = reg_wdata_in[ABU_BIT_BREAK_ENABLE];
            s_next.break_active = reg_wdata_in[ABU_BIT_BREAK_ACTIVE];
        end

        // Enable only gates clears of other blocks' flags
        if (reg_wr_in && sel(reg_addr_in, ABU_OFF_FLAG_CLEAR_CTRL))
        begin
            s_next.flag_clear_en = reg_wdata_in[ABU_BIT_FLAG_CLEAR_EN];
        end

        // Zero clears the wait-exit flag, a one is ignored
        if (reg_wr_in && sel(reg_addr_in, ABU_OFF_WAIT_EXIT_STATUS) && !reg_wdata_in[ABU_BIT_WAIT_EXIT])
        begin
            s_next.wait_exit = 1'b0;
        end

        // Status bits clear on a written one
        if (reg_wr_in && sel(reg_addr_in, ABU_OFF_IRQ_STATUS))
        begin
            s_next.irq_status = s_reg.irq_status & ~reg_wdata_in[ABU_IRQ_W-1:0];
        end

        if (reg_wr_in && sel(reg_addr_in, ABU_OFF_IRQ_MASK))
        begin
            s_next.irq_mask = reg_wdata_in[ABU_IRQ_W-1:0];
        end

        // Hardware set wins over a software clear in the same cycle
        if (addr_match)
        begin
            s_next.break_active = 1'b1;
            s_next.spent = 1'b1;
            irq_events[ABU_IRQ_MATCH] = 1'b1;
        end

        if (soft_req)
        begin
            irq_events[ABU_IRQ_SOFT] = 1'b1;
        end

        unique case (s_reg.state)
            ABU_ST_IDLE:
            begin
                // Opcode match: break before this instruction runs
                if (addr_match && cpu_opcode_fetch_in)
                begin
                    take_now = 1'b1;
                end
                // Operand match or software request waits for a boundary
                else if (addr_match || soft_req)
                begin
                    s_next.state = ABU_ST_PEND;
                end
            end

            ABU_ST_PEND:
            begin
                // Current instruction completes, break lands at its end
                if (cpu_instr_boundary_in)
                begin
                    take_now = 1'b1;
                end
            end

            ABU_ST_BREAK:
            begin
                // Held until the handler returns
                if (cpu_return_from_interrupt_in)
                begin
                    s_next.state = ABU_ST_IDLE;
                end
            end

            // Illegal code recovers to idle
            default:
            begin
                s_next.state = ABU_ST_IDLE;
            end
        endcase

        if (take_now)
        begin
            s_next.state = ABU_ST_BREAK;
            s_next.force_swi = 1'b1;
            s_next.vector = monitor_mode_in ? ABU_VECTOR_MONITOR : ABU_VECTOR_NORMAL;

            // Only a break that wakes the core from wait is noted
            if (wait_mode_in)
            begin
                s_next.wait_exit = 1'b1;
                irq_events[ABU_IRQ_WAIT_EXIT] = 1'b1;
            end
        end

        // Pin filter: only the second and third stages are compared
        s_next.tst_sync = {s_reg.tst_sync[ABU_SYNC_LEN-2:0], test_high_voltage_in};

        // Level changes only when two settled stages agree
        if (s_reg.tst_sync[1] == s_reg.tst_sync[2])
        begin
            s_next.tst_level = s_reg.tst_sync[2];
        end

        // Side effects follow the next state, so they rise with the force pulse
        s_next.timer_freeze = (s_next.state == ABU_ST_BREAK);

        // Watchdog stays alive unless the filtered test voltage is present
        s_next.wd_disable = (s_next.state == ABU_ST_BREAK) && s_next.tst_level;

        // Flag clears elsewhere are suppressed in break without the enable
        s_next.clear_allow = (s_next.state != ABU_ST_BREAK) || s_next.flag_clear_en;

        // Events are ORed in last so a set beats a clear
        s_next.irq_status = s_next.irq_status | irq_events;
        s_next.irq = |(s_next.irq_status & s_next.irq_mask);

        // Read data stands in the cycle after the strobe only
        s_next.rdata = ABU_RST_RDATA;
        if (reg_rd_in)
        begin
            if (sel(reg_addr_in, ABU_OFF_CONTROL_STATUS))
            begin
                s_next.rdata[ABU_BIT_BREAK_ENABLE] = s_reg.break_enable;
                s_next.rdata[ABU_BIT_BREAK_ACTIVE] = s_reg.break_active;
            end

            else if (sel(reg_addr_in, ABU_OFF_ADDR_HIGH))
            begin
                s_next.rdata = s_reg.addr_high;
            end

            else if (sel(reg_addr_in, ABU_OFF_ADDR_LOW))
            begin
                s_next.rdata = s_reg.addr_low;
            end

            else if (sel(reg_addr_in, ABU_OFF_FLAG_CLEAR_CTRL))
            begin
                s_next.rdata[ABU_BIT_FLAG_CLEAR_EN] = s_reg.flag_clear_en;
            end

            else if (sel(reg_addr_in, ABU_OFF_WAIT_EXIT_STATUS))
            begin
                s_next.rdata[ABU_BIT_WAIT_EXIT] = s_reg.wait_exit;
            end

            else if (sel(reg_addr_in, ABU_OFF_IRQ_STATUS))
            begin
                s_next.rdata[ABU_IRQ_W-1:0] = s_reg.irq_status;
            end

            else if (sel(reg_addr_in, ABU_OFF_IRQ_MASK))
            begin
                s_next.rdata[ABU_IRQ_W-1:0] = s_reg.irq_mask;
            end

            // Reserved and unmapped offsets read zero
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            // Sequencing and software-visible registers
            s_reg.state <= ABU_ST_IDLE;
            s_reg.addr_high <= ABU_RST_ADDR_BYTE;
            s_reg.addr_low <= ABU_RST_ADDR_BYTE;
            s_reg.break_enable <= 1'b0;
            s_reg.break_active <= 1'b0;
            s_reg.flag_clear_en <= 1'b0;
            s_reg.wait_exit <= 1'b0;
            s_reg.spent <= 1'b0;

            // Filter starts at the idle pin level, so no false edge follows
            s_reg.tst_sync <= '0;
            s_reg.tst_level <= 1'b0;

            // Interrupts
            s_reg.irq_status <= ABU_RST_IRQ;
            s_reg.irq_mask <= ABU_RST_IRQ;
            s_reg.irq <= 1'b0;

            // Outputs
            s_reg.breakpoint_request <= 1'b0;
            s_reg.force_swi <= 1'b0;
            s_reg.opcode <= SWI_OPCODE;
            s_reg.vector <= ABU_VECTOR_NORMAL;
            s_reg.timer_freeze <= 1'b0;
            s_reg.wd_disable <= 1'b0;
            s_reg.clear_allow <= 1'b1;
            s_reg.rdata <= ABU_RST_RDATA;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from a flip-flop

    assign reg_rdata_out = s_reg.rdata;
    assign breakpoint_request_out = s_reg.breakpoint_request;
    assign force_swi_out = s_reg.force_swi;
    assign software_interrupt_opcode_out = s_reg.opcode;
    assign break_vector_out = s_reg.vector;
    assign break_state_out = s_reg.state[2];
    assign timer_freeze_out = s_reg.timer_freeze;
    assign watchdog_disable_out = s_reg.wd_disable;
    assign flag_clear_allow_out = s_reg.clear_allow;
    assign irq_out = s_reg.irq;

endmodule // abu_core

// ==== core/abu_pkg.sv ====
/*
 * Constants of the address breakpoint unit: register offsets, field positions,
 * values after reset, break vectors and pin filter length.
 * Assumes a 16-bit register address space shared with the rest of the chip.
 */
package abu_pkg;

    // Register offsets
    localparam logic [15:0] ABU_OFF_WAIT_EXIT_STATUS = 16'hFE00;
    localparam logic [15:0] ABU_OFF_RESERVED_SLOT = 16'hFE02;
    localparam logic [15:0] ABU_OFF_FLAG_CLEAR_CTRL = 16'hFE03;
    localparam logic [15:0] ABU_OFF_ADDR_HIGH = 16'hFE09;
    localparam logic [15:0] ABU_OFF_ADDR_LOW = 16'hFE0A;
    localparam logic [15:0] ABU_OFF_CONTROL_STATUS = 16'hFE0B;
    localparam logic [15:0] ABU_OFF_IRQ_STATUS = 16'hFE10;
    localparam logic [15:0] ABU_OFF_IRQ_MASK = 16'hFE11;

    // Field positions
    localparam int ABU_BIT_BREAK_ENABLE = 7;
    localparam int ABU_BIT_BREAK_ACTIVE = 6;
    localparam int ABU_BIT_FLAG_CLEAR_EN = 7;
    localparam int ABU_BIT_WAIT_EXIT = 1;
    localparam int ABU_IRQ_MATCH = 0;
    localparam int ABU_IRQ_SOFT = 1;
    localparam int ABU_IRQ_WAIT_EXIT = 2;
    localparam int ABU_IRQ_W = 3;

    // Values after reset
    localparam logic [7:0] ABU_RST_ADDR_BYTE = 8'h00;
    localparam logic [ABU_IRQ_W-1:0] ABU_RST_IRQ = 3'h0;
    localparam logic [7:0] ABU_RST_RDATA = 8'h00;

    // Break vectors
    localparam logic [15:0] ABU_VECTOR_NORMAL = 16'hFFFC;
    localparam logic [15:0] ABU_VECTOR_MONITOR = 16'hFEFC;

    // Synchroniser length for the test-voltage pin
    localparam int ABU_SYNC_LEN = 3;

    typedef enum logic [2:0] {
        ABU_ST_IDLE = 3'b001,
        ABU_ST_PEND = 3'b010,
        ABU_ST_BREAK = 3'b100
    } abu_state_type;

endpackage

// ==== verification/abu_core_properties.sv ====
/*
 * Concurrent checks on the ports of the breakpoint unit.
 * Assumes it is bound to the core, which runs on one clock.
 */
`timescale 1ns/1ps
module abu_core_properties
    import abu_pkg::*;
#(
    parameter logic [7:0] SWI_OPCODE = 8'h00
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cpu_addr_valid_in,
    input wire logic cpu_opcode_fetch_in,
    input wire logic cpu_return_from_interrupt_in,
    input wire logic monitor_mode_in,
    input wire logic wait_mode_in,
    input wire logic stop_mode_in,
    input wire logic breakpoint_request_out,
    input wire logic force_swi_out,
    input wire logic [7:0] software_interrupt_opcode_out,
    input wire logic [15:0] break_vector_out,
    input wire logic break_state_out,
    input wire logic timer_freeze_out,
    input wire logic watchdog_disable_out,
    input wire logic flag_clear_allow_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////
    property p_req_gate;
        breakpoint_request_out |-> $past(cpu_addr_valid_in) && !$past(wait_mode_in) && !$past(stop_mode_in);
    endproperty
    a_req_gate: assert property (p_req_gate) else $error("request without a usable match");
    property p_opc;
        breakpoint_request_out && $past(cpu_opcode_fetch_in) && !$past(break_state_out) |-> force_swi_out;
    endproperty
    a_opc: assert property (p_opc) else $error("opcode match did not force");
    property p_once;
        breakpoint_request_out |=> !breakpoint_request_out;
    endproperty
    a_once: assert property (p_once) else $error("request repeated");
    property p_rise;
        $rose(break_state_out) |-> force_swi_out;
    endproperty
    a_rise: assert property (p_rise) else $error("break state without force");
    property p_vec;
        force_swi_out && $stable(monitor_mode_in)
            |-> break_vector_out == (monitor_mode_in ? ABU_VECTOR_MONITOR : ABU_VECTOR_NORMAL);
    endproperty
    a_vec: assert property (p_vec) else $error("wrong break vector");
    property p_rti;
        break_state_out && cpu_return_from_interrupt_in |=> !break_state_out;
    endproperty
    a_rti: assert property (p_rti) else $error("break state outlived return");
    property p_freeze;
        timer_freeze_out == break_state_out;
    endproperty
    a_freeze: assert property (p_freeze) else $error("timer freeze differs from break state");
    property p_wdog;
        watchdog_disable_out |-> break_state_out;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog off outside break");
    property p_allow;
        !break_state_out && !$past(break_state_out) |-> flag_clear_allow_out;
    endproperty
    a_allow: assert property (p_allow) else $error("flag clears blocked outside break");
    property p_opcode;
        software_interrupt_opcode_out == SWI_OPCODE;
    endproperty
    a_opcode: assert property (p_opcode) else $error("wrong forced opcode");
endmodule // abu_core_properties

// ==== verification/abu_core_tb.sv ====
/*
 * Self-checking bench of the breakpoint unit with a register model.
 * Assumes the CPU model file and the checker are compiled first.
 */
`timescale 1ns/1ps
module abu_core_tb;
    import abu_pkg::*;
    localparam logic [7:0] SOFTWARE_INTERRUPT_OPCODE = 8'h5A;
    logic clk_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, cpu_addr_valid_in = 0;
    logic cpu_opcode_fetch_in = 0, monitor_mode_in = 0, wait_mode_in = 0, stop_mode_in = 0;
    logic test_high_voltage_in = 0, cpu_instr_boundary_in, cpu_return_from_interrupt_in;
    logic [15:0] reg_addr_in = 0, cpu_addr_in = 0, break_vector_out;
    logic [7:0] reg_wdata_in = 0, reg_rdata_out, software_interrupt_opcode_out, bh = 0, bl = 0;
    logic breakpoint_request_out, force_swi_out, break_state_out, timer_freeze_out;
    logic watchdog_disable_out, flag_clear_allow_out, irq_out, en = 0, act = 0, fce = 0, wx = 0;
    logic [2:0] st = 0, mk = 0;
    int fails = 0, samples_checked = 0, seed = 32'hbb4f, i;
    logic [15:0] offs [9] = '{ABU_OFF_WAIT_EXIT_STATUS, ABU_OFF_RESERVED_SLOT, ABU_OFF_FLAG_CLEAR_CTRL,
        ABU_OFF_ADDR_HIGH, ABU_OFF_ADDR_LOW, ABU_OFF_CONTROL_STATUS, ABU_OFF_IRQ_STATUS, ABU_OFF_IRQ_MASK, 16'hFE05};
    abu_core #(.SWI_OPCODE(SOFTWARE_INTERRUPT_OPCODE)) u_dut (.*);
    abu_cpu_model u_cpu (.clk_in(clk_in), .rst_in(rst_in), .force_swi_in(force_swi_out), .hold_in(6'h14),
        .boundary_out(cpu_instr_boundary_in), .rti_out(cpu_return_from_interrupt_in));
    always #2.5 clk_in = ~clk_in;
    ////////////////////////////////////////////////////////////
    function automatic logic [7:0] mdl(logic [15:0] ad);
        case (ad)
            ABU_OFF_ADDR_HIGH: return bh;
            ABU_OFF_ADDR_LOW: return bl;
            ABU_OFF_CONTROL_STATUS: return {en, act, 6'h00};
            ABU_OFF_FLAG_CLEAR_CTRL: return {fce, 7'h00};
            ABU_OFF_WAIT_EXIT_STATUS: return {6'h00, wx, 1'b0};
            ABU_OFF_IRQ_STATUS: return {5'h00, st};
            ABU_OFF_IRQ_MASK: return {5'h00, mk};
            default: return 8'h00;
        endcase
    endfunction
    task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(logic [15:0] ad, logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in <= ad;
        reg_wdata_in <= d;
        reg_wr_in <= 1;
        @(posedge clk_in);
        reg_wr_in <= 0;
    endtask
    task automatic rd(logic [15:0] ad);
        @(posedge clk_in);
        reg_addr_in <= ad;
        reg_rd_in <= 1;
        @(posedge clk_in);
        reg_rd_in <= 0;
        #1 chk("rdata", reg_rdata_out, mdl(ad));
    endtask
    task automatic cpu(logic op);
        @(posedge clk_in);
        cpu_addr_in <= {bh, bl};
        cpu_addr_valid_in <= 1;
        cpu_opcode_fetch_in <= op;
        @(posedge clk_in);
        cpu_addr_valid_in <= 0;
        cpu_addr_in <= 16'($random(seed));
        #1;
    endtask
    // Bounded wait: w=0 for the force pulse, w=1 for the end of break
    task automatic wt(bit w);
        for (i = 0; i < 60; i++)
        begin
            @(posedge clk_in);
            #1;
            if ((w ? break_state_out : force_swi_out) === !w)
                return;
        end
        fails++;
        finish_test();
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge clk_in);
        rst_in <= 0;
        #1 chk("vector", break_vector_out, ABU_VECTOR_NORMAL);
        chk("opcode", software_interrupt_opcode_out, SOFTWARE_INTERRUPT_OPCODE);
        foreach (offs[k]) rd(offs[k]);
        $display("test reset done");
        {bh, bl} = 16'($random(seed));
        fce = 1;
        mk = 1;
        wr(ABU_OFF_ADDR_HIGH, bh);
        wr(ABU_OFF_ADDR_LOW, bl);
        wr(ABU_OFF_FLAG_CLEAR_CTRL, 8'h80);
        wr(ABU_OFF_IRQ_MASK, 8'h01);
        foreach (offs[k]) rd(offs[k]);
        wr(ABU_OFF_FLAG_CLEAR_CTRL, 8'h00);
        fce = 0;
        cpu(1);
        chk("breakpoint_request", breakpoint_request_out, 0);
        en = 1;
        wr(ABU_OFF_CONTROL_STATUS, 8'h80);
        for (int m = 0; m < 2; m++)
        begin
            wait_mode_in <= m == 0;
            stop_mode_in <= m == 1;
            cpu(1);
            chk("breakpoint_request", breakpoint_request_out, 0);
        end
        wait_mode_in <= 0;
        stop_mode_in <= 0;
        $display("test registers done");
        wr(ABU_OFF_ADDR_LOW, bl);
        cpu(1);
        act = 1;
        st = 1;
        chk("breakpoint_request", breakpoint_request_out, 1);
        chk("force", force_swi_out, 1);
        chk("freeze", timer_freeze_out, 1);
        rd(ABU_OFF_CONTROL_STATUS);
        chk("allow", flag_clear_allow_out, 0);
        chk("wdog", watchdog_disable_out, 0);
        chk("irq", irq_out, 1);
        wr(ABU_OFF_CONTROL_STATUS, 8'h80);
        act = 0;
        wt(1);
        rd(ABU_OFF_IRQ_STATUS);
        wr(ABU_OFF_IRQ_STATUS, 8'h07);
        st = 0;
        rd(ABU_OFF_IRQ_STATUS);
        chk("irq", irq_out, 0);
        cpu(1);
        chk("breakpoint_request", breakpoint_request_out, 0);
        $display("test opcode break done");
        bl = bl + 8'h01;
        fce = 1;
        wr(ABU_OFF_ADDR_LOW, bl);
        wr(ABU_OFF_FLAG_CLEAR_CTRL, 8'h80);
        monitor_mode_in <= 1;
        test_high_voltage_in <= 1;
        cpu(0);
        chk("force", force_swi_out, 0);
        wt(0);
        act = 1;
        chk("vector", break_vector_out, ABU_VECTOR_MONITOR);
        repeat (4) @(posedge clk_in);
        #1 chk("wdog", watchdog_disable_out, 1);
        chk("allow", flag_clear_allow_out, 1);
        wr(ABU_OFF_CONTROL_STATUS, 8'h80);
        act = 0;
        wt(1);
        monitor_mode_in <= 0;
        test_high_voltage_in <= 0;
        $display("test operand break done");
        wait_mode_in <= 1;
        wr(ABU_OFF_CONTROL_STATUS, 8'hC0);
        wt(0);
        wx = 1;
        wait_mode_in <= 0;
        wr(ABU_OFF_CONTROL_STATUS, 8'h80);
        wt(1);
        rd(ABU_OFF_WAIT_EXIT_STATUS);
        wr(ABU_OFF_WAIT_EXIT_STATUS, 8'h00);
        wx = 0;
        rd(ABU_OFF_WAIT_EXIT_STATUS);
        $display("test software break done");
        finish_test();
    end
endmodule // abu_core_tb

bind abu_core abu_core_properties #(.SWI_OPCODE(SWI_OPCODE)) u_props (.*);

// ==== verification/abu_cpu_model.sv ====
/*
 * Behavioural CPU core and integration unit beside the breakpoint unit.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module abu_cpu_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic force_swi_in,
    input wire logic [5:0] hold_in,
    output logic boundary_out,
    output logic rti_out
);
    logic [1:0] step_reg;
    logic [5:0] left_reg;
    // Handler length set by the bench through hold_in; the bench ties it to 6'h14, so every return takes the same time
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            step_reg <= 2'h0;
            left_reg <= 6'h00;
            boundary_out <= 1'b0;
            rti_out <= 1'b0;
        end
        else
        begin
            step_reg <= step_reg + 2'h1;
            boundary_out <= step_reg == 2'h3;
            left_reg <= force_swi_in ? hold_in : (left_reg != 6'h00 ? left_reg - 6'h01 : 6'h00);
            rti_out <= left_reg == 6'h01;
        end
    end
endmodule // abu_cpu_model
